/* File: hdl/acr_ctrl_bank.sv */
`timescale 1ns/10ps
`include "acr_params.svh"

module acr_ctrl_bank #(
  parameter int ADDR_W = 10
) (
  // Clock and reset
  input  wire logic                              CLK_IN,
  input  wire logic                              RST_N_IN,
  // Wishbone classic slave
  input  wire logic                              WB_CYC_IN,
  input  wire logic                              WB_STB_IN,
  input  wire logic                              WB_WE_IN,
  input  wire logic [ADDR_W-1:0]                 WB_ADR_IN,
  input  wire logic [3:0]                        WB_SEL_IN,
  input  wire logic [31:0]                       WB_DAT_IN,
  output logic                                   WB_ACK_OUT,
  output logic [31:0]                            WB_DAT_OUT,
  // Converter input pair select, bit 0 is converter 9
  output logic [3:0]                             PAIR_SELECT_OUT,
  // Per-line test pattern codes for lines 11 and 12
  output logic [2:0]                             PATTERN_CODE_LINE11_OUT,
  output logic [2:0]                             PATTERN_CODE_LINE12_OUT,
  output logic [1:0]                             PATTERN_OVERRIDE_OUT,
  // Sleep controls, bit 0 is converter or line 9
  output logic [3:0]                             DIGITAL_SLEEP_OUT,
  output logic [3:0]                             LINE_SLEEP_OUT,
  output logic [3:0]                             ANALOG_SLEEP_OUT,
  // Output line data for lines 9 to 12
  input  wire logic [3:0][`ACR_SAMPLE_W-1:0]     LINE_DATA_IN,
  input  wire logic [3:0]                        LINE_PATTERN_ACTIVE_IN,
  output logic [3:0][`ACR_SAMPLE_W-1:0]          LINE_DATA_OUT,
  // Odd sample of converter 13
  input  wire logic [`ACR_SAMPLE_W-1:0]          ODD_SAMPLE_IN,
  input  wire logic                              ODD_VALID_IN,
  output logic [`ACR_SAMPLE_W-1:0]               ODD_SAMPLE_OUT,
  output logic                                   ODD_VALID_OUT
);

  // ==========================================================================
  // Elaboration checks
  if (ADDR_W < 9 || ADDR_W > 32) begin : g_bad_addr_w
    $error("ADDR_W must lie between 9 and 32");
  end

  acr_pkg::acr_bank_state_s s_q;
  acr_pkg::acr_bank_state_s s_d;
  acr_pkg::acr_trim_cfg_s   trim_cfg;
  acr_pkg::acr_sample_s     odd_in;
  acr_pkg::acr_sample_s     odd_out;
  logic                     odd_sat;
  logic [7:0]               idx;
  logic                     upper_zero;
  logic                     req;
  logic                     wr_take;

  // ==========================================================================
  // Helpers

  // Byte lane merge; lanes 2 and 3 carry nothing for 16-bit registers
  function automatic logic [15:0] merge_lanes(input logic [15:0] old,
                                              input logic [31:0] wdata,
                                              input logic [3:0]  sel);
    logic [15:0] res;
    res = old;
    if (sel[0]) begin
      res[7:0] = wdata[7:0];
    end
    if (sel[1]) begin
      res[15:8] = wdata[15:8];
    end
    return res;
  endfunction : merge_lanes

  // Read mux, zero for an unmapped index
  function automatic logic [31:0] read_word(input acr_pkg::acr_regs_s regs,
                                            input logic [7:0]         index,
                                            input logic               hit_ok,
                                            input logic               sat);
    logic [15:0] val;
    val = 16'h0000;
    if (hit_ok) begin
      case (index)
        `ACR_IDX_SEL_PAT:   val = regs.sel_pat;
        `ACR_IDX_SLEEP_INV: val = regs.sleep_inv;
        `ACR_IDX_ODD_TRIM:  val = regs.odd_trim;
        `ACR_IDX_AUX: begin
          val                = regs.aux;
          val[`ACR_SAT_BIT]  = sat;
        end
        default:            val = 16'h0000;
      endcase
    end
    return {16'h0000, val};
  endfunction : read_word

  // Pass data, or its inverse when the line carries conversion data
  function automatic logic [`ACR_SAMPLE_W-1:0] line_word(
      input logic [`ACR_SAMPLE_W-1:0] data,
      input logic                     invert,
      input logic                     pattern_active);
    return (invert && !pattern_active) ? ~data : data;
  endfunction : line_word

  // ==========================================================================
  // Address decode: word index from the byte address, above it must be zero
  assign idx        = 8'(WB_ADR_IN[ADDR_W-1:2]);
  assign upper_zero = (ADDR_W <= 10) ? 1'b1 : (WB_ADR_IN[ADDR_W-1:2] >> 8) == '0;
  assign req        = WB_CYC_IN && WB_STB_IN;
  // The write lands on the edge at which the master sees ack
  assign wr_take    = req && WB_WE_IN && s_q.ack;

  // ==========================================================================
  // Next state of the bank
  always_comb begin
    s_d = s_q;

    // Ack one cycle after the request, dropped the cycle after
    s_d.ack = req && !s_q.ack;
    if (req && !s_q.ack) begin
      s_d.rdata = read_word(s_q.regs, idx, upper_zero, odd_sat);
    end else begin
      s_d.rdata = 32'h0000_0000;
    end

    // Register writes; unmapped writes are answered and dropped
    if (wr_take && upper_zero) begin
      case (idx)
        `ACR_IDX_SEL_PAT: begin
          s_d.regs.sel_pat = merge_lanes(s_q.regs.sel_pat, WB_DAT_IN, WB_SEL_IN);
        end
        `ACR_IDX_SLEEP_INV: begin
          s_d.regs.sleep_inv = merge_lanes(s_q.regs.sleep_inv, WB_DAT_IN, WB_SEL_IN);
        end
        `ACR_IDX_ODD_TRIM: begin
          s_d.regs.odd_trim = merge_lanes(s_q.regs.odd_trim, WB_DAT_IN, WB_SEL_IN);
        end
        `ACR_IDX_AUX: begin
          s_d.regs.aux = merge_lanes(s_q.regs.aux, WB_DAT_IN, WB_SEL_IN);
        end
        default: begin
          s_d.regs = s_q.regs;
        end
      endcase
    end
    // Saturation bit is status only, never stored
    s_d.regs.aux[`ACR_SAT_BIT] = 1'b0;

    // Input pair select, bit 0 drives converter 9
    s_d.pair_sel[0] = s_q.regs.sel_pat[`ACR_PAIR_SEL_LSB + 3];
    s_d.pair_sel[1] = s_q.regs.sel_pat[`ACR_PAIR_SEL_LSB + 2];
    s_d.pair_sel[2] = s_q.regs.sel_pat[`ACR_PAIR_SEL_LSB + 1];
    s_d.pair_sel[3] = s_q.regs.sel_pat[`ACR_PAIR_SEL_LSB];

    // Pattern codes reach the lines only while per-line patterns are on
    s_d.pat_override = {2{s_q.regs.aux[`ACR_PAT_EN_BIT]}};
    if (s_q.regs.aux[`ACR_PAT_EN_BIT]) begin
      s_d.pat11 = s_q.regs.sel_pat[`ACR_PAT11_LSB +: 3];
      s_d.pat12 = s_q.regs.sel_pat[`ACR_PAT12_LSB +: 3];
    end else begin
      s_d.pat11 = 3'h0;
      s_d.pat12 = 3'h0;
    end

    // Sleep controls; register bits run 12..9 from the top, ports 9..12 from bit 0
    for (int i = 0; i < 4; i++) begin
      s_d.dig_sleep[i]  = s_q.regs.sleep_inv[`ACR_DIG_SLEEP_LSB + i];
      s_d.line_sleep[i] = s_q.regs.sleep_inv[`ACR_LINE_SLEEP_LSB + i];
      s_d.ana_sleep[i]  = s_q.regs.sleep_inv[`ACR_ANA_SLEEP_LSB + i];
    end

    // Line data inversion, skipped while a pattern occupies the line
    for (int i = 0; i < 4; i++) begin
      s_d.line_data[i] = line_word(LINE_DATA_IN[i],
                                   s_q.regs.sleep_inv[`ACR_INVERT_LSB + i],
                                   LINE_PATTERN_ACTIVE_IN[i]);
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      s_q      <= '0;
      s_q.regs <= '{sel_pat:   `ACR_REG_RESET,
                    sleep_inv: `ACR_REG_RESET,
                    odd_trim:  `ACR_REG_RESET,
                    aux:       `ACR_REG_RESET};
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // Odd sample trim for converter 13; the reserved bit 10 is simply ignored
  assign trim_cfg.gain_en   = s_q.regs.aux[`ACR_GAIN_EN_BIT];
  assign trim_cfg.gain_code = s_q.regs.odd_trim[`ACR_GAIN_LSB +: 5];
  assign trim_cfg.offset_en = s_q.regs.aux[`ACR_OFFSET_EN_BIT];
  assign trim_cfg.offset    = s_q.regs.odd_trim[`ACR_OFFSET_LSB +: 10];
  assign odd_in.valid       = ODD_VALID_IN;
  assign odd_in.data        = ODD_SAMPLE_IN;

  acr_odd_trim u_odd_trim (
    .clk_in     (CLK_IN),
    .rst_n_in   (RST_N_IN),
    .cfg_in     (trim_cfg),
    .sample_in  (odd_in),
    .sample_out (odd_out),
    .sat_out    (odd_sat)
  );

  // ==========================================================================
  // Outputs, all straight from flip-flops
  assign WB_ACK_OUT              = s_q.ack;
  assign WB_DAT_OUT              = s_q.rdata;
  assign PAIR_SELECT_OUT         = s_q.pair_sel;
  assign PATTERN_CODE_LINE11_OUT = s_q.pat11;
  assign PATTERN_CODE_LINE12_OUT = s_q.pat12;
  assign PATTERN_OVERRIDE_OUT    = s_q.pat_override;
  assign DIGITAL_SLEEP_OUT       = s_q.dig_sleep;
  assign LINE_SLEEP_OUT          = s_q.line_sleep;
  assign ANALOG_SLEEP_OUT        = s_q.ana_sleep;
  assign LINE_DATA_OUT           = s_q.line_data;
  assign ODD_SAMPLE_OUT          = odd_out.data;
  assign ODD_VALID_OUT           = odd_out.valid;

endmodule : acr_ctrl_bank

/* File: hdl/acr_odd_trim.sv */
`timescale 1ns/10ps
`include "acr_params.svh"

module acr_odd_trim (
  // Clock and reset
  input  wire logic                     clk_in,
  input  wire logic                     rst_n_in,
  // Settings and sample in
  input  wire acr_pkg::acr_trim_cfg_s   cfg_in,
  input  wire acr_pkg::acr_sample_s     sample_in,
  // Trimmed sample out
  output acr_pkg::acr_sample_s          sample_out,
  output logic                          sat_out
);

  // ==========================================================================
  // Gain table: 10^(N*0.01) in Q3.12, one entry per 0.2 dB step
  localparam logic [31:0][14:0] GAIN_LUT = {
    15'h20AB, 15'h1FED, 15'h1F33, 15'h1E7D, 15'h1DCB, 15'h1D1D, 15'h1C74, 15'h1BCE,
    15'h1B2C, 15'h1A8E, 15'h19F3, 15'h195C, 15'h18C8, 15'h1838, 15'h17AA, 15'h1721,
    15'h169A, 15'h1616, 15'h1595, 15'h1518, 15'h149D, 15'h1425, 15'h13AF, 15'h133C,
    15'h12CC, 15'h125F, 15'h11F4, 15'h118B, 15'h1125, 15'h10C1, 15'h105F, 15'h1000};

  acr_pkg::acr_trim_state_s s_q;
  acr_pkg::acr_trim_state_s s_d;
  logic signed [14:0]       diff;
  logic signed [14:0]       gain;
  logic signed [29:0]       prod;
  logic signed [17:0]       scaled;

  // Offset first, then gain, so the offset unit stays one sample LSB
  always_comb begin
    s_d           = s_q;
    diff          = $signed({sample_in.data[`ACR_SAMPLE_W-1], sample_in.data});
    if (cfg_in.offset_en) begin
      diff = diff - $signed({{5{cfg_in.offset[9]}}, cfg_in.offset});
    end
    gain          = cfg_in.gain_en ? $signed(GAIN_LUT[cfg_in.gain_code])
                                   : $signed(`ACR_UNITY_GAIN);
    prod          = diff * gain;
    scaled        = prod[29:`ACR_GAIN_FRAC];
    s_d.out.valid = sample_in.valid;
    if (sample_in.valid) begin
      // Clip rather than wrap: a wrapped sample would look like a full-scale jump
      if (scaled > $signed({4'h0, `ACR_SAMPLE_MAX})) begin
        s_d.out.data = `ACR_SAMPLE_MAX;
        s_d.sat      = 1'b1;
      end else if (scaled < $signed({4'hF, `ACR_SAMPLE_MIN})) begin
        s_d.out.data = `ACR_SAMPLE_MIN;
        s_d.sat      = 1'b1;
      end else begin
        s_d.out.data = scaled[`ACR_SAMPLE_W-1:0];
        s_d.sat      = 1'b0;
      end
    end
  end

  // State register
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sample_out = s_q.out;
  assign sat_out    = s_q.sat;

endmodule : acr_odd_trim

/* File: hdl/acr_params.svh */
// What this block does
// - Converter 9 takes pair 17 in 16-input mode if bit 11 is 0, else 18.
// - Converter 10 takes pair 19 in 16-input mode if bit 10 is 0, else 20.
// - Converter 11 takes pair 21 in 16-input mode if bit 9 is 0, else 22.
// - Converter 12 takes pair 23 in 16-input mode if bit 8 is 0, else 24.
// - Bits 7..5 set the line 11 test pattern, only while per-line pattern enable is 1.
// - Bits 4..2 set the line 12 test pattern, only while per-line pattern enable is 1.
// - Bits 15..12 of 0x30 put digital blocks of converters 12..9 to sleep.
// - Bits 11..8 of 0x30 put output lines 12..9 to sleep.
// - Bits 7..4 of 0x30 put analog blocks of converters 12..9 to sleep.
// - Bits 3..0 of 0x30 invert conversion data on lines 12..9, never test patterns.
// - With gain enabled, odd converter 13 sample gets gain of N times 0.2 dB.
// - With offset enabled, subtract 10-bit signed offset from odd converter 13 sample.
`ifndef ACR_PARAMS_SVH
`define ACR_PARAMS_SVH

// ==========================================================================
// Register indices (byte address is four times the index)
`define ACR_IDX_SEL_PAT      8'h2F
`define ACR_IDX_SLEEP_INV    8'h30
`define ACR_IDX_ODD_TRIM     8'h31
`define ACR_IDX_AUX          8'h40
`define ACR_REG_RESET        16'h0000

// ==========================================================================
// Field positions
`define ACR_PAIR_SEL_LSB     8
`define ACR_PAT11_LSB        5
`define ACR_PAT12_LSB        2
`define ACR_DIG_SLEEP_LSB    12
`define ACR_LINE_SLEEP_LSB   8
`define ACR_ANA_SLEEP_LSB    4
`define ACR_INVERT_LSB       0
`define ACR_GAIN_LSB         11
`define ACR_OFFSET_LSB       0
`define ACR_GAIN_EN_BIT      12
`define ACR_OFFSET_EN_BIT    8
`define ACR_SAT_BIT          4
`define ACR_PAT_EN_BIT       0

// ==========================================================================
// Datapath figures
`define ACR_SAMPLE_W         14
`define ACR_GAIN_FRAC        12
`define ACR_UNITY_GAIN       15'h1000
`define ACR_SAMPLE_MAX       14'h1FFF
`define ACR_SAMPLE_MIN       14'h2000

`endif

/* File: hdl/acr_pkg.sv */
`include "acr_params.svh"

package acr_pkg;

  // ==========================================================================
  // Software visible registers, 16 bits each
  typedef struct packed {
    logic [15:0] sel_pat;
    logic [15:0] sleep_inv;
    logic [15:0] odd_trim;
    logic [15:0] aux;
  } acr_regs_s;

  // ==========================================================================
  // Trim settings for the odd converter 13 sample
  typedef struct packed {
    logic       gain_en;
    logic [4:0] gain_code;
    logic       offset_en;
    logic [9:0] offset;
  } acr_trim_cfg_s;

  // One sample with its valid flag
  typedef struct packed {
    logic                     valid;
    logic [`ACR_SAMPLE_W-1:0] data;
  } acr_sample_s;

  // State of the trim stage
  typedef struct packed {
    acr_sample_s out;
    logic        sat;
  } acr_trim_state_s;

  // ==========================================================================
  // State of the control bank
  typedef struct packed {
    acr_regs_s                     regs;
    logic                          ack;
    logic [31:0]                   rdata;
    logic [3:0]                    pair_sel;
    logic [2:0]                    pat11;
    logic [2:0]                    pat12;
    logic [1:0]                    pat_override;
    logic [3:0]                    dig_sleep;
    logic [3:0]                    line_sleep;
    logic [3:0]                    ana_sleep;
    logic [3:0][`ACR_SAMPLE_W-1:0] line_data;
  } acr_bank_state_s;

endpackage : acr_pkg

/* File: sim/acr_ctrl_bank_assertions.sv */
`timescale 1ns/10ps
`include "acr_params.svh"

// ==========================================================================
// Bus and output checks on the control bank ports
module acr_ctrl_bank_chk #(
  parameter int ADDR_W = 10
) (
  input wire logic                          CLK_IN,
  input wire logic                          RST_N_IN,
  input wire logic                          WB_CYC_IN,
  input wire logic                          WB_STB_IN,
  input wire logic                          WB_WE_IN,
  input wire logic [ADDR_W-1:0]             WB_ADR_IN,
  input wire logic [3:0]                    WB_SEL_IN,
  input wire logic [31:0]                   WB_DAT_IN,
  input wire logic                          WB_ACK_OUT,
  input wire logic [31:0]                   WB_DAT_OUT,
  input wire logic [3:0]                    PAIR_SELECT_OUT,
  input wire logic [2:0]                    PATTERN_CODE_LINE11_OUT,
  input wire logic [2:0]                    PATTERN_CODE_LINE12_OUT,
  input wire logic [1:0]                    PATTERN_OVERRIDE_OUT,
  input wire logic [3:0]                    DIGITAL_SLEEP_OUT,
  input wire logic [3:0]                    LINE_SLEEP_OUT,
  input wire logic [3:0]                    ANALOG_SLEEP_OUT,
  input wire logic [3:0][`ACR_SAMPLE_W-1:0] LINE_DATA_IN,
  input wire logic [3:0]                    LINE_PATTERN_ACTIVE_IN,
  input wire logic [3:0][`ACR_SAMPLE_W-1:0] LINE_DATA_OUT,
  input wire logic                          ODD_VALID_IN,
  input wire logic                          ODD_VALID_OUT
);
  // Full 16-bit writes at the ack edge; partial lanes would make the
  // expected outputs depend on old contents, so they are left out
  logic wr_all;
  logic wr_sel;
  logic wr_slp;
  assign wr_all = WB_CYC_IN & WB_STB_IN & WB_WE_IN & WB_ACK_OUT & (WB_SEL_IN[1:0] == 2'h3);
  assign wr_sel = wr_all & (WB_ADR_IN == ADDR_W'(16'h00BC));
  assign wr_slp = wr_all & (WB_ADR_IN == ADDR_W'(16'h00C0));

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  // ==========================================================================
  // Handshake
  chk_ack_single: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
    else $error("ack held longer than one cycle");
  chk_ack_prompt: assert property (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT |=> WB_ACK_OUT)
    else $error("request not answered in the next cycle");
  chk_rdata_idle: assert property (!WB_ACK_OUT |-> WB_DAT_OUT == 32'h0000_0000)
    else $error("read data not zero outside ack");

  // ==========================================================================
  // Derived outputs, two edges after the write lands
  chk_pair_select: assert property (wr_sel |-> ##2 PAIR_SELECT_OUT ==
    {$past(WB_DAT_IN[8], 2), $past(WB_DAT_IN[9], 2), $past(WB_DAT_IN[10], 2),
     $past(WB_DAT_IN[11], 2)}) else $error("pair select differs from written bits");
  chk_pat11_code: assert property (wr_sel |-> ##2 PATTERN_CODE_LINE11_OUT ==
    ($past(WB_DAT_IN[7:5], 2) & {3{PATTERN_OVERRIDE_OUT[0]}}))
    else $error("line 11 pattern code wrong");
  chk_pat12_code: assert property (wr_sel |-> ##2 PATTERN_CODE_LINE12_OUT ==
    ($past(WB_DAT_IN[4:2], 2) & {3{PATTERN_OVERRIDE_OUT[1]}}))
    else $error("line 12 pattern code wrong");
  chk_dig_sleep: assert property (wr_slp |-> ##2 DIGITAL_SLEEP_OUT ==
    $past(WB_DAT_IN[15:12], 2)) else $error("digital sleep wrong");
  chk_line_sleep: assert property (wr_slp |-> ##2 LINE_SLEEP_OUT ==
    $past(WB_DAT_IN[11:8], 2)) else $error("line sleep wrong");
  chk_ana_sleep: assert property (wr_slp |-> ##2 ANALOG_SLEEP_OUT ==
    $past(WB_DAT_IN[7:4], 2)) else $error("analog sleep wrong");

  // ==========================================================================
  // Data paths
  chk_pattern_pass: assert property (LINE_PATTERN_ACTIVE_IN == 4'hF |=>
    LINE_DATA_OUT == $past(LINE_DATA_IN)) else $error("test pattern was altered");
  chk_odd_valid: assert property ($past(RST_N_IN) |->
    ODD_VALID_OUT == $past(ODD_VALID_IN)) else $error("odd valid not one cycle late");

  cover property (wr_sel);
  cover property (wr_slp);
  cover property (ODD_VALID_OUT);
endmodule : acr_ctrl_bank_chk

bind acr_ctrl_bank acr_ctrl_bank_chk #(.ADDR_W(ADDR_W)) u_acr_ctrl_bank_chk (
  .CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN),
  .WB_WE_IN(WB_WE_IN), .WB_ADR_IN(WB_ADR_IN), .WB_SEL_IN(WB_SEL_IN),
  .WB_DAT_IN(WB_DAT_IN), .WB_ACK_OUT(WB_ACK_OUT), .WB_DAT_OUT(WB_DAT_OUT),
  .PAIR_SELECT_OUT(PAIR_SELECT_OUT), .PATTERN_CODE_LINE11_OUT(PATTERN_CODE_LINE11_OUT),
  .PATTERN_CODE_LINE12_OUT(PATTERN_CODE_LINE12_OUT),
  .PATTERN_OVERRIDE_OUT(PATTERN_OVERRIDE_OUT), .DIGITAL_SLEEP_OUT(DIGITAL_SLEEP_OUT),
  .LINE_SLEEP_OUT(LINE_SLEEP_OUT), .ANALOG_SLEEP_OUT(ANALOG_SLEEP_OUT),
  .LINE_DATA_IN(LINE_DATA_IN), .LINE_PATTERN_ACTIVE_IN(LINE_PATTERN_ACTIVE_IN),
  .LINE_DATA_OUT(LINE_DATA_OUT), .ODD_VALID_IN(ODD_VALID_IN), .ODD_VALID_OUT(ODD_VALID_OUT));

/* File: sim/acr_tb.sv */
`timescale 1ns/10ps
`include "acr_params.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
  $display("mismatch at %0t got %h exp %h", $time, (g), (e)); end end

// ==========================================================================
// Register bank bench, driven through its own bus and data ports
module testbench;
  logic                          clk = 1'b0;
  logic                          rst_n = 1'b0;
  logic                          cyc = 1'b0;
  logic                          stb = 1'b0;
  logic                          we = 1'b0;
  logic [9:0]                    adr = 10'h000;
  logic [3:0]                    sel = 4'h0;
  logic [31:0]                   dat = 32'h0000_0000;
  logic                          ack, ovld_o, ovld = 1'b0;
  logic [31:0]                   rdat;
  logic [3:0]                    pair, dig, lsl, ana, lpat = 4'h0;
  logic [2:0]                    c11, c12;
  logic [1:0]                    ovr;
  logic [3:0][`ACR_SAMPLE_W-1:0] ldat = '0, lout;
  logic [`ACR_SAMPLE_W-1:0]      osmp = 14'h0000, osmp_o;
  logic [31:0]                   q;
  int                            err_count = 0;
  int                            samples_checked = 0;

  acr_ctrl_bank u_acr_ctrl_bank (.CLK_IN(clk), .RST_N_IN(rst_n), .WB_CYC_IN(cyc),
    .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(dat),
    .WB_ACK_OUT(ack), .WB_DAT_OUT(rdat), .PAIR_SELECT_OUT(pair),
    .PATTERN_CODE_LINE11_OUT(c11), .PATTERN_CODE_LINE12_OUT(c12),
    .PATTERN_OVERRIDE_OUT(ovr), .DIGITAL_SLEEP_OUT(dig), .LINE_SLEEP_OUT(lsl),
    .ANALOG_SLEEP_OUT(ana), .LINE_DATA_IN(ldat), .LINE_PATTERN_ACTIVE_IN(lpat),
    .LINE_DATA_OUT(lout), .ODD_SAMPLE_IN(osmp), .ODD_VALID_IN(ovld),
    .ODD_SAMPLE_OUT(osmp_o), .ODD_VALID_OUT(ovld_o));

  initial begin
    forever #50 clk = ~clk;
  end

  task automatic test_done;
    $display("errors %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done

  // One classic cycle; the request stays put until ack is sampled high
  task automatic xfer(input logic w, input logic [9:0] a, input logic [3:0] s,
                      input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    sel <= s;
    dat <= {16'h0000, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      test_done();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    xfer(1'b1, a, 4'h3, d);
    @(posedge clk);
    #1;
  endtask : wr

  task automatic rd(input logic [9:0] a, input logic [15:0] e);
    xfer(1'b0, a, 4'hF, 16'h0000);
    `CHK(q, {16'h0000, e})
  endtask : rd

  task automatic lines(input logic [3:0] p, input logic [3:0][13:0] e);
    @(posedge clk);
    ldat <= {14'h0123, 14'h0456, 14'h0789, 14'h0ABC};
    lpat <= p;
    @(posedge clk);
    #1;
    `CHK(lout, e)
  endtask : lines

  // Trim settings, then one odd sample with its expected result
  task automatic trim(input logic [15:0] t, input logic [15:0] a, input logic [13:0] x,
                      input logic [13:0] e);
    wr(10'h0C4, t);
    wr(10'h100, a);
    @(posedge clk);
    osmp <= x;
    ovld <= 1'b1;
    @(posedge clk);
    ovld <= 1'b0;
    #1;
    `CHK({ovld_o, osmp_o}, {1'b1, e})
  endtask : trim

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    test_done();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd(10'h0BC, 16'h0000);
    rd(10'h0C0, 16'h0000);
    rd(10'h0C4, 16'h0000);
    `CHK({pair, dig, lsl, ana, c11, c12}, 22'h00_0000)
    for (int i = 0; i < 4; i++) begin
      wr(10'h0BC, 16'h0800 >> i);
      `CHK(pair, 4'h1 << i)
    end
    wr(10'h0BC, 16'h0AAC);
    `CHK({pair, c11, c12}, 10'h140)
    wr(10'h100, 16'h0001);
    wr(10'h0BC, 16'h0AAC);
    `CHK({ovr, c11, c12}, 8'hEB)
    for (int k = 0; k < 8; k++) begin
      wr(10'h0BC, 16'((k << 5) | ((7 - k) << 2)));
      `CHK({c11, c12}, 6'((k << 3) | (7 - k)))
    end
    wr(10'h0C0, 16'h9530);
    `CHK({dig, lsl, ana}, 12'h953)
    xfer(1'b1, 10'h0C0, 4'h1, 16'hFFFF);
    rd(10'h0C0, 16'h95FF);
    xfer(1'b1, 10'h0C0, 4'h2, 16'h0000);
    wr(10'h0C0, 16'h0005);
    `CHK({dig, lsl, ana}, 12'h000)
    lines(4'h4, {14'h0123, 14'h0456, 14'h0789, 14'h3543});
    wr(10'h0C0, 16'h000F);
    lines(4'hF, {14'h0123, 14'h0456, 14'h0789, 14'h0ABC});
    lines(4'h0, {14'h3EDC, 14'h3BA9, 14'h3876, 14'h3543});
    trim(16'h03F6, 16'h0100, 14'h0064, 14'h006E);
    trim(16'h0005, 16'h0100, 14'h2000, 14'h2000);
    trim(16'h0005, 16'h0000, 14'h0064, 14'h0064);
    trim(16'hF800, 16'h1000, 14'h0100, 14'h020A);
    trim(16'hF800, 16'h1000, 14'h3F00, 14'h3DF5);
    trim(16'h0800, 16'h1000, 14'h1000, 14'h105F);
    trim(16'hF800, 16'h0000, 14'h0100, 14'h0100);
    trim(16'hF800, 16'h1000, 14'h1000, 14'h1FFF);
    rd(10'h100, 16'h1010);
    trim(16'hFB00, 16'h1100, 14'h0000, 14'h020A);
    rd(10'h0C4, 16'hFB00);
    wr(10'h104, 16'hFFFF);
    rd(10'h104, 16'h0000);
    rd(10'h0BC, 16'h00E0);
    // Mid-run reset must clear registers 0x2F and 0x40, the status flag, the control outputs and the odd sample
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(10'h0BC, 16'h0000);
    rd(10'h100, 16'h0000);
    `CHK({pair, ovr, c11, c12, dig, lsl, ana, ovld_o, osmp_o}, 39'h00_0000_0000)
    test_done();
  end
endmodule : testbench
